// >>> rtl/dasp_pkg.sv
// Purpose: shared constants and types for the first async serial port
// Assumes: 250 MHz core clock
// Notes: timing counts derived from clock rate and bit rate
package dasp_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int unsigned CLOCK_HZ = 250_000_000;
   localparam int unsigned BAUD_MIN = 115_200;
   localparam int unsigned BAUD_MAX = 921_600;
   localparam int unsigned BAUD_DEFAULT = 115_200;
   localparam int unsigned DIV_W = 16;
   // ----------------------------------------
   // framing
   // ----------------------------------------
   localparam int unsigned DATA_BITS = 8;
   localparam int unsigned STOP_BITS = 1;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned FIFO_SPARE = 2;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic HS_ACTIVE = 1'b0;
   localparam logic HS_INACTIVE = 1'b1;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef logic [DATA_BITS-1:0] dasp_byte_type;
   typedef struct packed {
      logic valid;
      dasp_byte_type data;
   } dasp_char_type;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_START,
      ST_DATA,
      ST_STOP
   } dasp_state_type;
endpackage

// >>> rtl/dasp_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: depth is a power of two
// Notes: read data comes from a register
module dasp_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // write side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // read side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH):0] level
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW:0] wptr_reg;
   logic [AW:0] rptr_reg;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign count = wptr_reg - rptr_reg;
   assign level = count;
   assign in_ready = (count != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign push = in_valid & in_ready;
   // output register refills as soon as it is consumed
   assign pop = (count != '0) & (~out_valid | out_ready);

   always_ff @(posedge clock) begin
      if (push) begin
         mem_reg[wptr_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         if (push) begin
            wptr_reg <= wptr_reg + 1'b1;
         end
         if (pop) begin
            rptr_reg <= rptr_reg + 1'b1;
            out_data <= mem_reg[rptr_reg[AW-1:0]];
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule // dasp_fifo

// >>> rtl/dasp_port.sv
// Purpose: first async serial port, module side (dce) of a 4-wire link
// Assumes: line inputs synchronous to clock; rate fixed per build
// Notes: modem control pins are plain gpio pass-through
//
// Functional notes
// - each character is 8 data bits, one stop bit, no parity, both ways.
// - the port runs at one fixed bit rate between 115200 and 921600 bps, no autobaud; BAUD is not checked against this range, and the bench builds 12500000.
// - transmit waits while the host send request is inactive; clear-to-send drops two slots short of full.
// - data low is 0 and high is 1; handshake lines are active low.
// - the module takes serial data and send request in, drives serial out and clear-to-send.
// - only the two data and two handshake lines carry the link; the modem control pins have no modem function.
// - a low carrier detect line while starting up selects firmware download mode.
// - the unused modem control pins act as general-purpose pins; carrier detect is also the startup strap.
module dasp_port #(
   parameter int unsigned BAUD = dasp_pkg::BAUD_DEFAULT,
   parameter int unsigned DEPTH = dasp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // serial link
   input wire logic serial_in_from_host,
   input wire logic host_send_request_n,
   output logic serial_out_to_host,
   output logic module_clear_to_send_n,
   // transmit stream from core
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // receive stream to core
   output logic rx_valid,
   input wire logic rx_ready,
   output logic [7:0] rx_data,
   output logic rx_frame_error,
   // startup strap
   input wire logic startup_phase,
   output logic download_mode,
   // general-purpose pins
   input wire logic [3:0] gpio_in,
   input wire logic [3:0] gpio_out,
   input wire logic [3:0] gpio_oe,
   output logic [3:0] gpio_pin_out,
   output logic [3:0] gpio_pin_oe,
   output logic [3:0] gpio_pin_in
);
   // ----------------------------------------
   // derived timing
   // ----------------------------------------
   // bit period rounds down; the rate error stays small at this clock
   localparam int unsigned BIT_CYC = dasp_pkg::CLOCK_HZ / BAUD;
   localparam logic [dasp_pkg::DIV_W-1:0] BIT_LAST = dasp_pkg::DIV_W'(BIT_CYC - 1);
   localparam logic [dasp_pkg::DIV_W-1:0] HALF_LAST = dasp_pkg::DIV_W'(BIT_CYC / 2 - 1);
   localparam logic [2:0] LAST_BIT = 3'(dasp_pkg::DATA_BITS - 1);
   localparam int unsigned LW = $clog2(DEPTH) + 1;
   localparam logic [LW-1:0] FULL_MARK = LW'(DEPTH - dasp_pkg::FIFO_SPARE);

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // handshake lines are active low in both directions
   function automatic logic hs_active(input logic line);
      return line == dasp_pkg::HS_ACTIVE;
   endfunction
   // divider compare shared by both directions
   function automatic logic count_done(input logic [dasp_pkg::DIV_W-1:0] div,
                                       input logic [dasp_pkg::DIV_W-1:0] last);
      return div == last;
   endfunction

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   // two flops so the release never lands near a clock edge
   logic rst_meta_reg;
   logic rst_n;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n <= rst_meta_reg;
      end
   end

   // ----------------------------------------
   // startup strap and gpio
   // ----------------------------------------
   // gpio index 1 doubles as carrier detect input during startup
   // strap sampled every startup cycle, last value wins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         download_mode <= 1'b0;
      end else if (startup_phase) begin
         download_mode <= hs_active(gpio_in[1]);
      end
   end

   // modem lines carry no handshake meaning here
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gpio_pin_out <= '0;
      end else begin
         gpio_pin_out <= gpio_out;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gpio_pin_oe <= '0;
      end else begin
         gpio_pin_oe <= gpio_oe;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gpio_pin_in <= '0;
      end else begin
         gpio_pin_in <= gpio_in;
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   dasp_pkg::dasp_state_type tx_state_reg;
   logic [dasp_pkg::DIV_W-1:0] tx_div_reg;
   logic [2:0] tx_bit_reg;
   dasp_pkg::dasp_byte_type tx_shift_reg;
   logic tx_tick;
   assign tx_tick = count_done(tx_div_reg, BIT_LAST);

   // bit timer restarts at every boundary and rests while idle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_div_reg <= '0;
      end else if (tx_state_reg == dasp_pkg::ST_IDLE || tx_tick) begin
         tx_div_reg <= '0;
      end else begin
         tx_div_reg <= tx_div_reg + 1'b1;
      end
   end

   // tx_ready is a one-cycle take pulse; the core drops tx_valid after it
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tx_state_reg <= dasp_pkg::ST_IDLE;
         tx_bit_reg <= '0;
         tx_shift_reg <= '0;
         tx_ready <= 1'b0;
         serial_out_to_host <= dasp_pkg::LINE_IDLE;
      end else begin
         tx_ready <= 1'b0;
         case (tx_state_reg)
            dasp_pkg::ST_IDLE: begin
               serial_out_to_host <= dasp_pkg::LINE_IDLE;
               // hold off while host send request is inactive
               if (tx_valid && !tx_ready && hs_active(host_send_request_n)) begin
                  tx_shift_reg <= tx_data;
                  tx_ready <= 1'b1;
                  tx_state_reg <= dasp_pkg::ST_START;
                  serial_out_to_host <= 1'b0;
               end
            end
            dasp_pkg::ST_START: begin
               if (tx_tick) begin
                  serial_out_to_host <= tx_shift_reg[0];
                  tx_shift_reg <= tx_shift_reg >> 1;
                  tx_bit_reg <= '0;
                  tx_state_reg <= dasp_pkg::ST_DATA;
               end
            end
            dasp_pkg::ST_DATA: begin
               if (tx_tick) begin
                  if (tx_bit_reg == LAST_BIT) begin
                     serial_out_to_host <= dasp_pkg::LINE_IDLE;
                     tx_state_reg <= dasp_pkg::ST_STOP;
                  end else begin
                     serial_out_to_host <= tx_shift_reg[0];
                     tx_shift_reg <= tx_shift_reg >> 1;
                     tx_bit_reg <= tx_bit_reg + 1'b1;
                  end
               end
            end
            default: begin
               // single stop bit, no parity
               if (tx_tick) begin
                  tx_state_reg <= dasp_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // receiver
   // ----------------------------------------
   dasp_pkg::dasp_state_type rx_state_reg;
   logic [dasp_pkg::DIV_W-1:0] rx_div_reg;
   logic [2:0] rx_bit_reg;
   dasp_pkg::dasp_byte_type rx_shift_reg;
   dasp_pkg::dasp_char_type rx_char_reg;
   logic fifo_ready;
   logic [LW-1:0] fifo_level;
   logic rx_point;
   // hold register waits for fifo room; an ignored cts can overwrite it

   // sample point: mid start bit, then one bit period apart
   assign rx_point = (rx_state_reg == dasp_pkg::ST_START) ? count_done(rx_div_reg, HALF_LAST)
                                                          : count_done(rx_div_reg, BIT_LAST);

   // divider rests in idle so the start edge sets the phase
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_div_reg <= '0;
      end else if (rx_state_reg == dasp_pkg::ST_IDLE || rx_point) begin
         rx_div_reg <= '0;
      end else begin
         rx_div_reg <= rx_div_reg + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rx_state_reg <= dasp_pkg::ST_IDLE;
         rx_bit_reg <= '0;
         rx_shift_reg <= '0;
         rx_char_reg <= '0;
         rx_frame_error <= 1'b0;
      end else begin
         rx_frame_error <= 1'b0;
         if (rx_char_reg.valid && fifo_ready) begin
            rx_char_reg.valid <= 1'b0;
         end
         case (rx_state_reg)
            dasp_pkg::ST_IDLE: begin
               if (serial_in_from_host == 1'b0) begin
                  rx_state_reg <= dasp_pkg::ST_START;
               end
            end
            dasp_pkg::ST_START: begin
               // centre of start bit; a short glitch aborts
               if (rx_point) begin
                  rx_bit_reg <= '0;
                  rx_state_reg <= serial_in_from_host ? dasp_pkg::ST_IDLE : dasp_pkg::ST_DATA;
               end
            end
            dasp_pkg::ST_DATA: begin
               if (rx_point) begin
                  rx_shift_reg <= {serial_in_from_host, rx_shift_reg[7:1]};
                  rx_bit_reg <= rx_bit_reg + 1'b1;
                  if (rx_bit_reg == LAST_BIT) begin
                     rx_state_reg <= dasp_pkg::ST_STOP;
                  end
               end
            end
            default: begin
               if (rx_point) begin
                  rx_state_reg <= dasp_pkg::ST_IDLE;
                  if (serial_in_from_host == dasp_pkg::LINE_IDLE) begin
                     // overflow drops only if the host ignored clear-to-send
                     rx_char_reg.valid <= 1'b1;
                     rx_char_reg.data <= rx_shift_reg;
                  end else begin
                     rx_frame_error <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // receive buffer and flow control
   // ----------------------------------------
   dasp_fifo #(
      .WIDTH(dasp_pkg::DATA_BITS),
      .DEPTH(DEPTH)
   ) u_rx_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(rx_char_reg.valid),
      .in_ready(fifo_ready),
      .in_data(rx_char_reg.data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .out_data(rx_data),
      .level(fifo_level)
   );

   // spare slots cover a character already in flight when cts drops
   // level leaves out the fifo output register, which holds one byte more
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         module_clear_to_send_n <= dasp_pkg::HS_INACTIVE;
      end else if (fifo_level >= FULL_MARK) begin
         module_clear_to_send_n <= dasp_pkg::HS_INACTIVE;
      end else begin
         module_clear_to_send_n <= dasp_pkg::HS_ACTIVE;
      end
   end
endmodule // dasp_port

// >>> tb/dasp_checker.sv
// Purpose: port assertions for dasp_port
// Assumes: bound with a short bit period
// Notes: frame timing counted from tx_ready
module dasp_checker #(
   parameter int unsigned BAUD = dasp_pkg::BAUD_DEFAULT,
   parameter int unsigned DEPTH = dasp_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // link and streams
   input wire logic host_send_request_n,
   input wire logic serial_out_to_host,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_frame_error,
   // strap and gpio
   input wire logic startup_phase,
   input wire logic download_mode,
   input wire logic [3:0] gpio_in,
   input wire logic [3:0] gpio_out,
   input wire logic [3:0] gpio_pin_out
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int B = 250_000_000 / BAUD;
   localparam int MID0 = B + B / 2;
   localparam int MID7 = 8 * B + B / 2;
   localparam int STOP = 9 * B + B / 2;
   logic [7:0] byte_reg;
   int frame_cnt;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // frame window, so a low line outside a frame is caught
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         byte_reg <= 8'h00;
         frame_cnt <= 0;
      end else if (tx_ready) begin
         byte_reg <= tx_data;
         frame_cnt <= 10 * B;
      end else if (frame_cnt > 0) begin
         frame_cnt <= frame_cnt - 1;
      end
   end
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_pulse; tx_ready |=> !tx_ready; endproperty
   a_pulse: assert property (p_pulse) else $error("tx_ready too long");
   property p_hold; tx_ready |-> $past(tx_valid) && !$past(host_send_request_n); endproperty
   a_hold: assert property (p_hold) else $error("send while held off");
   property p_start; tx_ready |-> !serial_out_to_host [*8]; endproperty
   a_start: assert property (p_start) else $error("start bit short");
   property p_bit0; tx_ready |-> ##MID0 serial_out_to_host == byte_reg[0]; endproperty
   a_bit0: assert property (p_bit0) else $error("first data bit wrong");
   property p_bit7; tx_ready |-> ##MID7 serial_out_to_host == byte_reg[7]; endproperty
   a_bit7: assert property (p_bit7) else $error("last data bit wrong");
   property p_stop; tx_ready |-> ##STOP serial_out_to_host; endproperty
   a_stop: assert property (p_stop) else $error("stop bit low");
   property p_idle; !serial_out_to_host |-> tx_ready || frame_cnt != 0; endproperty
   a_idle: assert property (p_idle) else $error("line low outside frame");
   property p_rxhold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
   a_rxhold: assert property (p_rxhold) else $error("rx byte dropped");
   property p_ferr; rx_frame_error |=> !rx_frame_error; endproperty
   a_ferr: assert property (p_ferr) else $error("frame error too long");
   property p_strap; startup_phase |=> download_mode == !$past(gpio_in[1]); endproperty
   a_strap: assert property (p_strap) else $error("strap not taken");
   property p_gpio; gpio_pin_out == $past(gpio_out); endproperty
   a_gpio: assert property (p_gpio) else $error("gpio copy wrong");
   c_tx: cover property (tx_ready);
   c_rx: cover property (rx_valid && rx_ready);
   c_ferr: cover property (rx_frame_error);
endmodule // dasp_checker

bind dasp_port dasp_checker #(.BAUD(BAUD), .DEPTH(DEPTH)) chk (.*);

// >>> tb/dasp_host_model.sv
// Purpose: host terminal model on the serial link
// Assumes: same bit period as the port
// Notes: send request is set by the bench
module dasp_host_model #(
   parameter int B = 20
) (
   // clock
   input wire logic clock,
   // link
   output logic serial_in_from_host,
   output logic host_send_request_n,
   input wire logic serial_out_to_host,
   input wire logic module_clear_to_send_n
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] rxq[$];
   initial begin
      serial_in_from_host = 1'b1;
      host_send_request_n = 1'b1;
   end
   // bad stop value only when a bench task asks for it
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 400 && module_clear_to_send_n !== 1'b0; i++) @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         @(posedge clock);
         #1 serial_in_from_host = f[i];
         repeat (B - 1) @(posedge clock);
      end
      @(posedge clock);
      #1 serial_in_from_host = 1'b1;
   endtask
   // receiver, sampled mid-bit
   initial begin
      logic [7:0] d;
      forever begin
         @(posedge clock);
         if (serial_out_to_host === 1'b0) begin
            repeat (B / 2) @(posedge clock);
            for (int i = 0; i < 8; i++) begin
               repeat (B) @(posedge clock);
               d[i] = serial_out_to_host;
            end
            repeat (B) @(posedge clock);
            if (serial_out_to_host === 1'b1) rxq.push_back(d);
         end
      end
   end
endmodule // dasp_host_model

// >>> tb/tb_top.sv
// Purpose: self-checking bench for dasp_port
// Assumes: 4 ns clock, 20-cycle bit period
// Notes: host side is dasp_host_model
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int B = 20;
   logic clock, reset_n, tx_valid, rx_ready, startup_phase, tx_ready, rx_valid;
   logic serial_in_from_host, host_send_request_n, serial_out_to_host, rx_frame_error;
   logic module_clear_to_send_n, download_mode;
   logic [7:0] tx_data, rx_data;
   logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_pin_out, gpio_pin_oe, gpio_pin_in;
   logic [7:0] got[$];
   int n_fail, checks_done, n_ferr;
   dasp_port #(.BAUD(12_500_000), .DEPTH(8)) dut (.*);
   dasp_host_model #(.B(B)) host (.*);
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(posedge clock) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) got.push_back(rx_data);
      if (rx_frame_error === 1'b1) n_ferr++;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_len(input int want, input bit from_host);
      for (int i = 0; i < 15 * B * want + 100; i++) begin
         if ((from_host ? host.rxq.size() : got.size()) >= want) return;
         @(posedge clock);
      end
      n_fail++;
      give_verdict();
   endtask
   task automatic core_send(input logic [7:0] b);
      @(posedge clock);
      #1 tx_valid = 1'b1;
      tx_data = b;
      for (int i = 0; i < 20 * B; i++) begin
         @(posedge clock);
         #1;
         if (tx_ready === 1'b1) begin
            tx_valid = 1'b0;
            return;
         end
      end
      n_fail++;
      give_verdict();
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_rx();
      logic [7:0] pat[4] = '{8'h00, 8'hA5, 8'hFF, 8'h3C};
      got.delete();
      #1 rx_ready = 1'b1;
      foreach (pat[i]) host.send(pat[i], 1'b1);
      wait_len(4, 1'b0);
      foreach (pat[i]) check(got[i], pat[i]);
   endtask
   task automatic t_ferr();
      n_ferr = 0;
      got.delete();
      host.send(8'h55, 1'b0);
      host.send(8'h96, 1'b1);
      wait_len(1, 1'b0);
      check(8'(n_ferr), 8'h01);
      check(got[0], 8'h96);
   endtask
   task automatic t_tx();
      int moved;
      moved = 0;
      host.rxq.delete();
      fork
         core_send(8'h5A);
      join_none
      repeat (5 * B) begin
         @(posedge clock);
         if (tx_ready !== 1'b0 || serial_out_to_host !== 1'b1) moved++;
      end
      check(8'(moved), 8'h00);
      #1 host.host_send_request_n = 1'b0;
      wait fork;
      core_send(8'h81);
      wait_len(2, 1'b1);
      check(host.rxq[0], 8'h5A);
      check(host.rxq[1], 8'h81);
   endtask
   task automatic t_flow();
      got.delete();
      #1 rx_ready = 1'b0;
      // one byte sits in the fifo output register, six more reach the mark
      for (int i = 0; i < 7; i++) host.send(8'h10 + i[7:0], 1'b1);
      repeat (10) @(posedge clock);
      check(8'(module_clear_to_send_n), 8'h01);
      #1 rx_ready = 1'b1;
      wait_len(7, 1'b0);
      for (int i = 0; i < 7; i++) check(got[i], 8'h10 + i[7:0]);
      repeat (4) @(posedge clock);
      check(8'(module_clear_to_send_n), 8'h00);
   endtask
   task automatic t_gpio();
      #1 gpio_out = 4'h5;
      gpio_oe = 4'hA;
      gpio_in = 4'h9;
      repeat (2) @(posedge clock);
      check(8'({gpio_pin_out, gpio_pin_oe}), 8'h5A);
      check(8'(gpio_pin_in), 8'h09);
      #1 startup_phase = 1'b1;
      repeat (3) @(posedge clock);
      check(8'(download_mode), 8'h01);
      #1 startup_phase = 1'b0;
      gpio_in = 4'hF;
      repeat (3) @(posedge clock);
      check(8'(download_mode), 8'h01);
      #1 startup_phase = 1'b1;
      repeat (3) @(posedge clock);
      check(8'(download_mode), 8'h00);
   endtask
   initial begin
      reset_n = 1'b0;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      startup_phase = 1'b0;
      tx_data = 8'h00;
      gpio_in = 4'hF;
      gpio_out = 4'h0;
      gpio_oe = 4'h0;
      n_fail = 0;
      checks_done = 0;
      repeat (2) @(posedge clock);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clock);
      check(8'({serial_out_to_host, module_clear_to_send_n}), 8'h02);
      t_rx();
      t_ferr();
      t_tx();
      t_flow();
      t_gpio();
      give_verdict();
   end
endmodule // tb_top
